// File: logic/rles_lane_gate.sv
/*
 lane gating unit: decides which of the four lanes run, from either the snooped
 lane count and power state or the software lane-off bits.
 assumes inputs are registered values from the bank in the same clock domain.
*/
`timescale 1ns/100ps
module rles_lane_gate
   import rles_pkg::*;
(
   input  wire logic       i_clk,        // device clock
   input  wire logic       i_sys_rst,    // async reset, active high
   input  wire rles_gate_e i_gate_src,   // snoop or register gating
   input  wire logic [1:0] i_mode,       // mode select field
   input  wire logic [1:0] i_pwr_state,  // captured power state
   input  wire logic [4:0] i_lane_count, // captured lane count
   input  wire logic [3:0] i_lane_off,   // software lane-off bits
   output logic      [3:0] o_lane_en     // registered lane enables
);

   logic [3:0] next_lane_en;

   always_comb begin
      next_lane_en = 4'h0;
      if (i_mode == RLES_MODE_ACTIVE) begin
         case (i_gate_src)
            RLES_GATE_SNOOP: begin
               // lane-off bits are ignored here, only the snooped values count
               if (i_pwr_state == RLES_PWR_ON) begin
                  next_lane_en = rles_count_mask(i_lane_count);
               end
            end
            RLES_GATE_REG: begin
               next_lane_en = ~i_lane_off;
            end
            default: begin
               next_lane_en = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_lane_en <= 4'h0;
      end else begin
         o_lane_en <= next_lane_en;
      end
   end

endmodule

// File: logic/rles_pkg.sv
/*
 package for the lane equalization and snoop register bank: offsets, field positions,
 reset values, mode codes and the carrier structs shared by the bank and its gating unit.
 assumes a single device clock; no other file defines these names.
*/
package rles_pkg;

   localparam logic [7:0] RLES_OFS_GENERAL   = 8'h0A;
   localparam logic [7:0] RLES_OFS_EQ_UPPER  = 8'h11;
   localparam logic [7:0] RLES_OFS_SNOOP_ST  = 8'h12;
   localparam logic [7:0] RLES_OFS_LANE_CTL  = 8'h13;

   localparam logic [7:0] RLES_RST_GENERAL   = 8'h01;
   localparam logic [7:0] RLES_RST_EQ_UPPER  = 8'h00;
   localparam logic [7:0] RLES_RST_SNOOP_ST  = 8'h00;
   localparam logic [7:0] RLES_RST_LANE_CTL  = 8'h00;

   localparam int RLES_POS_EQ_REGISTER_SOURCE = 4;
   localparam int RLES_POS_MODE_LO     = 0;
   localparam int RLES_POS_MODE_HI     = 1;
   localparam int RLES_POS_LANE3_EQ_LO = 4;
   localparam int RLES_POS_LANE2_EQ_LO = 0;
   localparam int RLES_POS_PWR_LO      = 5;
   localparam int RLES_POS_PWR_HI      = 6;
   localparam int RLES_POS_LCNT_HI     = 4;
   localparam int RLES_POS_SNOOP_OFF   = 7;

   // writable bits of the general and lane control registers
   localparam logic [7:0] RLES_WMASK_GENERAL  = 8'h BF;
   localparam logic [7:0] RLES_WMASK_LANE_CTL = 8'h BF;

   localparam logic [19:0] RLES_AUX_ADDR_PWR  = 20'h0_0600;
   localparam logic [19:0] RLES_AUX_ADDR_LCNT = 20'h0_0101;

   localparam logic [1:0] RLES_MODE_OFF_LOW   = 2'h0;
   localparam logic [1:0] RLES_MODE_OFF_IDLE  = 2'h1;
   localparam logic [1:0] RLES_MODE_ACTIVE    = 2'h2;

   localparam logic [1:0] RLES_PWR_ON         = 2'h1;

   typedef enum logic {
      RLES_GATE_SNOOP,
      RLES_GATE_REG
   } rles_gate_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } rles_req_s;

   typedef struct packed {
      logic        valid;
      logic [19:0] addr;
      logic [7:0]  data;
   } rles_aux_s;

   function automatic logic [3:0] rles_count_mask(input logic [4:0] cnt);
      case (cnt)
         5'h01:   rles_count_mask = 4'h1;
         5'h02:   rles_count_mask = 4'h3;
         5'h04:   rles_count_mask = 4'hF;
         default: rles_count_mask = 4'h0;
      endcase
   endfunction

endpackage

// File: logic/rles_regs.sv
/*
 register bank of the redriver: general mode, lane 2/3 equalization, snoop status and
 lane gating control, plus the AUX write snooper that fills the status fields.
 assumes a register port already decoded from the serial host (one-cycle strobes) and
 an AUX write monitor that presents each observed write as a one-cycle valid.
*/
// Functional notes
// - lane 3 equalization, bits 7-4 at 0x11, follows the strap pins unless override is set.
// - lane 2 equalization, bits 3-0 at 0x11, follows the strap pins unless override is set.
// - an AUX write to 0x00600 while snooping is on is captured into status bits 6-5 as the power state.
// - an AUX write to 0x00101 while snooping is on is captured into status bits 4-0 as the lane count.
// - with snooping on, only lanes called for by the lane count run.
// - with snooping on, the captured power state also gates the lanes.
// - both captured fields clear when mode select bit 1 falls from 1 to 0.
// - control bit 7 at 0x13 chooses snoop gating (0) or register gating (1).
// - control bits 3-0 switch off lanes 3-0 while snooping is off.
// - lane-off bits are stored but have no effect while snooping is on.
// - status at 0x12 is read-only, hardware-updated, bit 7 reads zero.
// - general bit 4 picks strap pins (0) or register nibbles (1) for equalization.
// - general bits 1-0 select mode; software writes 2 to run the display path.
`timescale 1ns/100ps
module rles_regs
   import rles_pkg::*;
(
   input  wire logic       i_clk,        // device clock, 50 MHz
   input  wire logic       i_sys_rst,    // async reset, active high
   input  wire rles_req_s  i_req,        // register access from the serial host
   input  wire rles_aux_s  i_aux,        // observed AUX write
   input  wire logic [1:0] i_eq_strap_pins, // equalization strap pins
   output logic      [7:0] o_rdata,      // read data, valid the cycle after i_req.rd
   output logic            o_rvalid,     // read data valid pulse
   output logic      [3:0] o_lane2_eq,   // equalization applied to lane 2
   output logic      [3:0] o_lane3_eq,   // equalization applied to lane 3
   output logic      [1:0] o_mode,       // mode select field
   output logic      [3:0] o_lane_en     // lane enables
);

   logic [7:0] general;
   logic [7:0] eq_select_upper_lanes;
   logic [1:0] pwr_state;
   logic [4:0] lane_count;
   logic [7:0] lane_gating_control;
   logic [1:0] strap_q;
   logic [3:0] strap_eq;
   logic       mode_bit1_fall;
   logic       eq_register_source;
   logic [7:0] snoop_capture_status;
   logic [7:0] next_rdata;
   rles_gate_e gate_src;

   assign eq_register_source   = general[RLES_POS_EQ_REGISTER_SOURCE];
   assign snoop_capture_status = {1'b0, pwr_state, lane_count};
   assign gate_src = lane_gating_control[RLES_POS_SNOOP_OFF] ? RLES_GATE_REG
                                                             : RLES_GATE_SNOOP;
   // strap code widened into one nibble; pins are static so one register stage suffices
   assign strap_eq = {2'b00, strap_q};
   assign mode_bit1_fall = general[RLES_POS_MODE_HI] & i_req.wr
                         & (i_req.addr == RLES_OFS_GENERAL)
                         & ~i_req.wdata[RLES_POS_MODE_HI];

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         strap_q <= 2'h0;
      end else begin
         strap_q <= i_eq_strap_pins;
      end
   end

   // general mode register
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         general <= RLES_RST_GENERAL;
      end else if (i_req.wr && i_req.addr == RLES_OFS_GENERAL) begin
         general <= i_req.wdata & RLES_WMASK_GENERAL;
      end
   end

   // equalization nibbles: mirror the straps until software takes over
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         eq_select_upper_lanes <= RLES_RST_EQ_UPPER;
      end else if (!eq_register_source) begin
         eq_select_upper_lanes <= {strap_eq, strap_eq};
      end else if (i_req.wr && i_req.addr == RLES_OFS_EQ_UPPER) begin
         eq_select_upper_lanes <= i_req.wdata;
      end
   end

   // snoop capture; a capture in the cycle of the mode fall clear wins, so that a
   // sink write seen at that moment is not lost
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pwr_state  <= RLES_RST_SNOOP_ST[RLES_POS_PWR_HI:RLES_POS_PWR_LO];
         lane_count <= RLES_RST_SNOOP_ST[RLES_POS_LCNT_HI:0];
      end else begin
         if (mode_bit1_fall) begin
            pwr_state  <= 2'h0;
            lane_count <= 5'h00;
         end
         if (i_aux.valid && gate_src == RLES_GATE_SNOOP) begin
            if (i_aux.addr == RLES_AUX_ADDR_PWR) begin
               pwr_state <= i_aux.data[RLES_POS_PWR_HI-RLES_POS_PWR_LO:0];
            end
            if (i_aux.addr == RLES_AUX_ADDR_LCNT) begin
               lane_count <= i_aux.data[RLES_POS_LCNT_HI:0];
            end
         end
      end
   end

   // lane gating control; bit 6 reads zero and is not writable
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lane_gating_control <= RLES_RST_LANE_CTL;
      end else if (i_req.wr && i_req.addr == RLES_OFS_LANE_CTL) begin
         lane_gating_control <= i_req.wdata & RLES_WMASK_LANE_CTL;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      case (i_req.addr)
         RLES_OFS_GENERAL:  next_rdata = general;
         RLES_OFS_EQ_UPPER: next_rdata = eq_select_upper_lanes;
         RLES_OFS_SNOOP_ST: next_rdata = snoop_capture_status;
         RLES_OFS_LANE_CTL: next_rdata = lane_gating_control;
         default:           next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_req.rd;
         if (i_req.rd) begin
            o_rdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_lane2_eq <= 4'h0;
         o_lane3_eq <= 4'h0;
         o_mode     <= RLES_RST_GENERAL[RLES_POS_MODE_HI:RLES_POS_MODE_LO];
      end else begin
         o_lane2_eq <= eq_select_upper_lanes[RLES_POS_LANE2_EQ_LO +: 4];
         o_lane3_eq <= eq_select_upper_lanes[RLES_POS_LANE3_EQ_LO +: 4];
         o_mode     <= general[RLES_POS_MODE_HI:RLES_POS_MODE_LO];
      end
   end

   rles_lane_gate u_gate (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_gate_src   (gate_src),
      .i_mode       (general[RLES_POS_MODE_HI:RLES_POS_MODE_LO]),
      .i_pwr_state  (pwr_state),
      .i_lane_count (lane_count),
      .i_lane_off   (lane_gating_control[3:0]),
      .o_lane_en    (o_lane_en)
   );

endmodule

// File: verif/rles_aux_src.sv
/*
 far-side model: the aux channel as seen by the snooper, one write per i_go.
 assumes the bench raises i_go for one cycle per write.
*/
`timescale 1ns/100ps
module rles_aux_src
   import rles_pkg::*;
(
   input  wire logic        i_clk,  // device clock
   input  wire logic        i_go,   // send one write
   input  wire logic [19:0] i_addr, // aux address
   input  wire logic [7:0]  i_data, // aux data byte
   output rles_aux_s        o_aux   // observed write
);
   initial o_aux = '0;
   // between writes the lines flip so a stale value is never mistaken for data
   always @(posedge i_clk) begin
      if (i_go) o_aux <= '{1'b1, i_addr, i_data};
      else o_aux <= '{1'b0, ~o_aux.addr, ~o_aux.data};
   end
endmodule

// File: verif/rles_regs_properties.sv
/*
 port checker of the lane equalization and snoop register bank.
 assumes it is bound to rles_regs and sees only its ports, one clock domain.
*/
`timescale 1ns/100ps
module rles_regs_chk
   import rles_pkg::*;
(
   input  wire logic       i_clk,           // device clock
   input  wire logic       i_sys_rst,       // async reset, active high
   input  wire rles_req_s  i_req,           // host access
   input  wire rles_aux_s  i_aux,           // observed aux write
   input  wire logic [1:0] i_eq_strap_pins, // strap pins
   input  wire logic [7:0] o_rdata,         // read data
   input  wire logic       o_rvalid,        // read strobe
   input  wire logic [3:0] o_lane2_eq,      // lane 2 eq
   input  wire logic [3:0] o_lane3_eq,      // lane 3 eq
   input  wire logic [1:0] o_mode,          // mode field
   input  wire logic [3:0] o_lane_en        // lane enables
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_read_answer; i_req.rd |=> o_rvalid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_status_bit7; i_req.rd && i_req.addr == RLES_OFS_SNOOP_ST |=> !o_rdata[7]; endproperty
   a_status_bit7: assert property (p_status_bit7) else $error("status bit 7 set");
   property p_resv_bit6;
      i_req.rd && (i_req.addr == RLES_OFS_GENERAL || i_req.addr == RLES_OFS_LANE_CTL)
      |=> !o_rdata[6];
   endproperty
   a_resv_bit6: assert property (p_resv_bit6) else $error("reserved bit 6 set");
   property p_mode_follow;
      i_req.wr && i_req.addr == RLES_OFS_GENERAL |=> ##1 o_mode == $past(i_req.wdata[1:0], 2);
   endproperty
   a_mode_follow: assert property (p_mode_follow) else $error("mode not updated");
   property p_idle_lanes_off; (o_mode != RLES_MODE_ACTIVE) [*2] |-> o_lane_en == 4'h0; endproperty
   a_idle_lanes_off: assert property (p_idle_lanes_off) else $error("lanes on in idle");
   // a capture in the clearing cycle or the one after may legally refill the field
   property p_clear_on_fall;
      $fell(o_mode[1]) && !$past(i_aux.valid) && !$past(i_aux.valid, 2) && i_req.rd
      && i_req.addr == RLES_OFS_SNOOP_ST |=> o_rdata == 8'h00;
   endproperty
   a_clear_on_fall: assert property (p_clear_on_fall) else $error("status not cleared");
   // straps reach the outputs three edges after a reset release, so skip that window
   property p_eq_steady;
      (!i_req.wr && $stable(i_eq_strap_pins)) [*4] ##0 !$past(i_sys_rst, 4)
      |-> $stable({o_lane3_eq, o_lane2_eq});
   endproperty
   a_eq_steady: assert property (p_eq_steady) else $error("eq moved unprompted");
   property p_lanes_steady; (!i_req.wr && !i_aux.valid) [*4] |-> $stable(o_lane_en); endproperty
   a_lanes_steady: assert property (p_lanes_steady) else $error("lanes moved");
endmodule

// File: verif/tb.sv
/*
 self-checking bench of the register bank: host tasks, aux model, random gating.
 assumes rles_pkg, the design, the checker and the aux model compile first.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb;
   import rles_pkg::*;
   logic        i_clk = 1'b0, i_sys_rst = 1'b1, go = 1'b0, rvalid;
   rles_req_s   i_req = '0;
   rles_aux_s   aux;
   logic [1:0]  strap = 2'h0, mode;
   logic [19:0] go_addr = '0;
   logic [7:0]  go_data = '0, rdata, r;
   logic [3:0]  eq2, eq3, lane_en;
   logic [4:0]  c;
   int          errors = 0, total_checks = 0, n;
   always #10 i_clk = ~i_clk;
   rles_aux_src u_aux (.i_clk(i_clk), .i_go(go), .i_addr(go_addr), .i_data(go_data), .o_aux(aux));
   rles_regs u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_aux(aux),
      .i_eq_strap_pins(strap), .o_rdata(rdata), .o_rvalid(rvalid), .o_lane2_eq(eq2),
      .o_lane3_eq(eq3), .o_mode(mode), .o_lane_en(lane_en));
   function automatic logic [3:0] exp_lanes(input logic [4:0] cnt, input logic [1:0] pwr);
      exp_lanes = 4'h0;
      if (pwr == 2'h1) exp_lanes = (cnt == 5'h01) ? 4'h1 : (cnt == 5'h02) ? 4'h3 :
                                   (cnt == 5'h04) ? 4'hF : 4'h0;
   endfunction
   task automatic stop_test;
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic settle;
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk) i_req <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk) i_req <= '0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
      @(posedge i_clk) i_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk) i_req <= '0;
      #1;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) #20;
      if (n == 4) begin
         errors++;
         stop_test();
      end
      `CHK("rdata", ex, rdata)
   endtask
   task automatic snoop(input logic [19:0] a, input logic [7:0] d);
      @(posedge i_clk) begin go <= 1'b1; go_addr <= a; go_data <= d; end
      @(posedge i_clk) go <= 1'b0;
      settle();
   endtask
   initial begin
      void'($urandom(68));
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd_chk(RLES_OFS_GENERAL, RLES_RST_GENERAL);
      rd_chk(RLES_OFS_LANE_CTL, RLES_RST_LANE_CTL);
      rd_chk(8'h20, 8'h00);
      wr(RLES_OFS_GENERAL, 8'h02);
      for (int k = 0; k < 4; k++) begin
         r = 8'($urandom);
         strap <= r[1:0];
         wr(RLES_OFS_EQ_UPPER, r);
         settle();
         `CHK("eq3", {2'h0, r[1:0]}, eq3)
         `CHK("eq2", {2'h0, r[1:0]}, eq2)
         `CHK("mode", RLES_MODE_ACTIVE, mode)
      end
      wr(RLES_OFS_GENERAL, 8'h12);
      for (int k = 0; k < 4; k++) begin
         r = 8'($urandom);
         wr(RLES_OFS_EQ_UPPER, r);
         settle();
         `CHK("eq3", r[7:4], eq3)
         `CHK("eq2", r[3:0], eq2)
      end
      snoop(RLES_AUX_ADDR_PWR, 8'hFD);
      for (int k = 0; k < 6; k++) begin
         c = (k == 0) ? 5'h01 : (k == 1) ? 5'h02 : (k == 5) ? 5'h04 : 5'($urandom);
         snoop(RLES_AUX_ADDR_LCNT, {3'h7, c});
         `CHK("lanes", exp_lanes(c, 2'h1), lane_en)
         rd_chk(RLES_OFS_SNOOP_ST, {3'h1, c});
      end
      snoop(RLES_AUX_ADDR_PWR, 8'h02);
      `CHK("lanes", 4'h0, lane_en)
      rd_chk(RLES_OFS_SNOOP_ST, 8'h44);
      snoop(RLES_AUX_ADDR_PWR, 8'h01);
      wr(RLES_OFS_LANE_CTL, 8'h0F);
      settle();
      `CHK("lanes", 4'hF, lane_en)
      rd_chk(RLES_OFS_LANE_CTL, 8'h0F);
      wr(RLES_OFS_SNOOP_ST, 8'hFF);
      rd_chk(RLES_OFS_SNOOP_ST, 8'h24);
      for (int k = 0; k < 8; k++) begin
         r = 8'($urandom) | 8'h80;
         wr(RLES_OFS_LANE_CTL, r);
         settle();
         `CHK("lanes", ~r[3:0], lane_en)
         rd_chk(RLES_OFS_LANE_CTL, r & RLES_WMASK_LANE_CTL);
      end
      snoop(RLES_AUX_ADDR_LCNT, 8'h01);
      rd_chk(RLES_OFS_SNOOP_ST, 8'h24);
      wr(RLES_OFS_LANE_CTL, 8'h00);
      settle();
      `CHK("lanes", 4'hF, lane_en)
      wr(RLES_OFS_GENERAL, 8'h00);
      rd_chk(RLES_OFS_SNOOP_ST, 8'h00);
      `CHK("lanes", 4'h0, lane_en)
      `CHK("mode", RLES_MODE_OFF_LOW, mode)
      wr(RLES_OFS_GENERAL, 8'h12);
      snoop(RLES_AUX_ADDR_LCNT, 8'h02);
      `CHK("lanes", 4'h0, lane_en)
      rd_chk(RLES_OFS_SNOOP_ST, 8'h02);
      // second reset in mid-run: mode, lanes, status and general must return to their reset values
      @(posedge i_clk) i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      `CHK("mode", RLES_RST_GENERAL[1:0], mode)
      `CHK("lanes", 4'h0, lane_en)
      rd_chk(RLES_OFS_SNOOP_ST, RLES_RST_SNOOP_ST);
      rd_chk(RLES_OFS_GENERAL, RLES_RST_GENERAL);
      stop_test();
   end
endmodule
bind rles_regs rles_regs_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
   .i_aux(i_aux), .i_eq_strap_pins(i_eq_strap_pins), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
   .o_lane2_eq(o_lane2_eq), .o_lane3_eq(o_lane3_eq), .o_mode(o_mode), .o_lane_en(o_lane_en));
